// ---- rtl/utd_regs.svh ----
// Register offsets, field positions, reset values and widths of the termination decode
`ifndef UTD_REGS_SVH
`define UTD_REGS_SVH

`define UTD_CTRL_OFFSET       12'h000
`define UTD_STATUS_OFFSET     12'h004

`define UTD_CTRL_SPEED_LSB    0
`define UTD_CTRL_TERM_BIT     2
`define UTD_CTRL_OPERATING_MODE_LSB   3
`define UTD_CTRL_REQ_A_BIT    5
`define UTD_CTRL_REQ_B_BIT    6
`define UTD_CTRL_WIDTH        7

`define UTD_STAT_PULLUP_BIT   0
`define UTD_STAT_DP_PD_BIT    1
`define UTD_STAT_DM_PD_BIT    2
`define UTD_STAT_HSTERM_BIT   3
`define UTD_STAT_WIDTH        4
`define UTD_ENABLES_RESET     4'h6

`define UTD_SPEED_RESET       2'h1
`define UTD_TERM_RESET        1'h0
`define UTD_OPERATING_MODE_RESET      2'h0
`define UTD_REQ_A_RESET       1'h1
`define UTD_REQ_B_RESET       1'h1

`define UTD_SPEED_HIGH        2'h0
`define UTD_OPERATING_MODE_NODRIVE    2'h1

`endif

// ---- rtl/utd_pkg.sv ----
// Types shared by the termination decode
package utd_pkg;

  typedef struct packed {
    logic       request_b;
    logic       request_a;
    logic [1:0] operating_mode;
    logic       termination_select;
    logic [1:0] speed_select;
  } utd_ctrl_t;

  typedef struct packed {
    logic highspeed_termination_enable;
    logic request_b_enable;
    logic request_a_enable;
    logic dp_pullup_enable;
  } utd_enables_t;

  typedef enum logic [2:0] {
    UTD_APB_IDLE   = 3'h1,
    UTD_APB_SETUP  = 3'h2,
    UTD_APB_ACCESS = 3'h4
  } utd_apb_state_t;

endpackage

// ---- rtl/utd_termination_decode.sv ----
// APB-reached line resistor decode for a USB 2.0 transceiver
// What this block does
// RULE_01: Resistor enables come only from speed, termination, mode and two pull-down requests.
// RULE_02: Pull-up enable output switches the 1.5 kilohm pull-up on DP.
// RULE_03: DP pull-down enable output switches the 15 kilohm pull-down on DP.
// RULE_04: DM pull-down enable output switches the 15 kilohm pull-down on DM.
// RULE_05: Termination enable switches the 45 ohm terminations on DP and DM together.
// RULE_06: The link programs all controls itself; the block never sequences them.
// RULE_07: Operating mode 01b turns all four resistor enables off.
// RULE_08: Power-up setting enables only the two pull-downs.
// RULE_09: Host chirp, high-speed and test states: pull-downs plus termination, no pull-up.
// RULE_10: Host full-speed, low-speed and suspend: pull-downs only.
// RULE_11: Host resume keeps the pull-downs only pattern.
// RULE_12: Peripheral chirp: pull-up on, no termination, DM pull-down follows request.
// RULE_13: Peripheral high-speed and test: termination only plus requested DM pull-down.
// RULE_14: Peripheral full-speed, suspend, resume: pull-up, no termination.
// RULE_15: Outside mode 01b, pull-down enables follow their request bits directly.
`timescale 1ns/100ps

`include "utd_regs.svh"

module utd_termination_decode #(
  parameter int ADDR_W = 12
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output utd_pkg::utd_enables_t     line_enables
);

  // Offsets need at least the one word-select bit above the two byte-lane bits
  if (ADDR_W < 3) begin : g_addr_check
    $error("utd_termination_decode: ADDR_W must be at least 3");
  end

  utd_pkg::utd_ctrl_t     ctrl_q;
  utd_pkg::utd_ctrl_t     ctrl_d;
  utd_pkg::utd_enables_t  enables_q;
  utd_pkg::utd_enables_t  enables_d;
  utd_pkg::utd_apb_state_t state_q;
  utd_pkg::utd_apb_state_t state_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   err_q;
  logic                   err_d;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] offset);
    logic [ADDR_W-1:0] off_w;
    off_w = ADDR_W'(offset);
    hit = (addr[ADDR_W-1:2] == off_w[ADDR_W-1:2]);
  endfunction

  wire logic setup_phase  = psel && !penable;
  wire logic access_phase = psel && penable;
  wire logic hit_ctrl     = hit(paddr, `UTD_CTRL_OFFSET);
  wire logic hit_status   = hit(paddr, `UTD_STATUS_OFFSET);
  wire logic hit_any      = hit_ctrl || hit_status;
  // Status is read only: a write to it is refused like an unmapped one
  wire logic bad_access   = !hit_any || (pwrite && hit_status);
  wire logic write_ctrl   = access_phase && pwrite && hit_ctrl && (pstrb[0] == 1'b1);

  // Only byte lane 0 carries control bits; other lanes are accepted and dropped
  assign ctrl_d = write_ctrl ? utd_pkg::utd_ctrl_t'(pwdata[`UTD_CTRL_WIDTH-1:0]) : ctrl_q;

  // Decode of the five controls into the resistor enables [RULE_01]
  wire logic mode_nodrive = (ctrl_q.operating_mode == `UTD_OPERATING_MODE_NODRIVE);
  wire logic speed_high   = (ctrl_q.speed_select == `UTD_SPEED_HIGH);
  // Pull-up only for a peripheral with full-speed terminations [RULE_12] [RULE_14]
  wire logic pullup_on    = ctrl_q.termination_select && !ctrl_q.request_a;
  // Termination whenever high-speed is chosen with terminations off [RULE_09] [RULE_13]
  wire logic hsterm_on    = !ctrl_q.termination_select && speed_high;

  // Mode 01b overrides everything else [RULE_07]
  assign enables_d.dp_pullup_enable             = !mode_nodrive && pullup_on;        // [RULE_02]
  assign enables_d.request_a_enable           = !mode_nodrive && ctrl_q.request_a; // [RULE_03] [RULE_15]
  assign enables_d.request_b_enable           = !mode_nodrive && ctrl_q.request_b; // [RULE_04] [RULE_15]
  // One enable drives both line terminations so they never split [RULE_05]
  assign enables_d.highspeed_termination_enable = !mode_nodrive && hsterm_on;
  // Host states with termination select 1b land on pull-downs only [RULE_10] [RULE_11]
  // Reset controls give the pull-downs only pattern [RULE_08]
  // The controls are stored as written, with no sequencing of our own [RULE_06]

  wire logic [31:0] ctrl_word   = {{(32-`UTD_CTRL_WIDTH){1'b0}}, ctrl_q};
  wire logic [31:0] status_word = {{(32-`UTD_STAT_WIDTH){1'b0}}, enables_q};

  // Read data is captured in the setup cycle so it leaves a flip-flop
  assign rdata_d = !setup_phase ? rdata_q :
                   (pwrite || bad_access) ? 32'h0000_0000 :
                   hit_ctrl ? ctrl_word : status_word;
  assign err_d   = setup_phase ? bad_access : err_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      utd_pkg::UTD_APB_IDLE: begin
        if (setup_phase) begin
          state_d = utd_pkg::UTD_APB_SETUP;
        end
      end
      utd_pkg::UTD_APB_SETUP: begin
        state_d = access_phase ? utd_pkg::UTD_APB_ACCESS : utd_pkg::UTD_APB_IDLE;
      end
      utd_pkg::UTD_APB_ACCESS: begin
        state_d = setup_phase ? utd_pkg::UTD_APB_SETUP : utd_pkg::UTD_APB_IDLE;
      end
      default: begin
        state_d = utd_pkg::UTD_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.speed_select       <= `UTD_SPEED_RESET;
      ctrl_q.termination_select <= `UTD_TERM_RESET;
      ctrl_q.operating_mode     <= `UTD_OPERATING_MODE_RESET;
      ctrl_q.request_a          <= `UTD_REQ_A_RESET;
      ctrl_q.request_b          <= `UTD_REQ_B_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Reset pattern matches the decode of the reset controls: pull-downs only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_q <= `UTD_ENABLES_RESET;
    end else begin
      enables_q <= enables_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= utd_pkg::UTD_APB_IDLE;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign pready       = 1'b1;
  assign pslverr      = access_phase && err_q;
  assign prdata       = rdata_q;
  assign line_enables = enables_q;

endmodule

// ---- verif/utd_decode_monitor.sv ----
// Checker for the termination decode outputs
`timescale 1ns/100ps
module utd_decode_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input utd_pkg::utd_enables_t  line_enables
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
  wire              wr  = psel && penable && pready && pwrite && idx == '0 && pstrb[0];
  wire              on  = wr && pwdata[4:3] != 2'h1;
  // Enables are registered behind the stored controls: visible two edges after the write
  AST_OFF: assert property (wr && pwdata[4:3] == 2'h1 |-> ##2 line_enables == 4'h0)
    else $error("enables not off in mode 01");
  AST_DPPD: assert property (on |-> ##2 line_enables[1] == $past(pwdata[5], 2))
    else $error("dp pull-down wrong");
  AST_DMPD: assert property (on |-> ##2 line_enables[2] == $past(pwdata[6], 2))
    else $error("dm pull-down wrong");
  AST_PU: assert property (on |-> ##2 line_enables[0] == $past(pwdata[2] & ~pwdata[5], 2))
    else $error("pull-up wrong");
  AST_HS: assert property (on |-> ##2 line_enables[3] == $past(~pwdata[2] & ~|pwdata[1:0], 2))
    else $error("termination wrong");
  AST_HOLD: assert property (!$past(wr) |=> $stable(line_enables))
    else $error("enables moved without a write");
  AST_RST: assert property ($rose(presetn) |-> line_enables == 4'h6)
    else $error("reset pattern wrong");
  AST_RD: assert property (psel && !penable && !pwrite && idx == 1 |=>
    prdata == {28'h0, $past(line_enables)}) else $error("status read wrong");
endmodule

bind utd_termination_decode utd_decode_monitor #(.ADDR_W(ADDR_W)) i_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .line_enables(line_enables));

// ---- verif/utd_link_model.sv ----
// Link-side APB master that programs the termination controls
`timescale 1ns/100ps
module utd_link_model (
  input  wire logic pclk,
  input  wire logic pready,
  output logic      psel,
  output logic      penable,
  output logic      pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0]  pstrb,
  output logic      hung
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb, hung} = '0;
  // One word per transfer; the link alone decides the order of settings
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    hung <= (n >= 20);
    {psel, penable} <= 2'b00;
    // Released data must not look valid
    pwdata <= ~d;
  endtask
endmodule

// ---- verif/usb_termination_state_decode_tb.sv ----
// Self-checking bench for the termination decode
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module usb_termination_state_decode_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [6:0]  c;
  logic [32:0] exp_q[$];
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 32'h0763410f;
  utd_pkg::utd_enables_t line_enables;
  logic [10:0] tbl[16] = '{{7'h6F, 4'h0}, {7'h61, 4'h6}, {7'h70, 4'hE}, {7'h60, 4'hE},
    {7'h65, 4'h6}, {7'h67, 4'h6}, {7'h75, 4'h6}, {7'h66, 4'h6}, {7'h14, 4'h1}, {7'h54, 4'h5},
    {7'h00, 4'h8}, {7'h40, 4'hC}, {7'h10, 4'h8}, {7'h05, 4'h1}, {7'h45, 4'h5}, {7'h50, 4'hC}};
  always #5 pclk = ~pclk;
  utd_termination_decode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_enables(line_enables));
  utd_link_model i_link (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .hung());
  function automatic logic [3:0] dec(input logic [6:0] v);
    return (v[4:3] == 2'h1) ? 4'h0 : {~v[2] & ~|v[1:0], v[6], v[5], v[2] & ~v[5]};
  endfunction
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [32:0] e);
    exp_q.push_back(e);
    i_link.xfer(w, a, d, s);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Write responses carry no data, so only the error bit is judged there
  always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
    `CHK({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front())
  end
  always @(posedge i_link.hung) begin
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, 12'h004, 32'h0, 4'hF, 33'h6);
    xf(0, 12'h000, 32'h0, 4'hF, 33'h61);
    $display("test reset done");
    foreach (tbl[i]) begin
      xf(1, 12'h000, {25'h0, tbl[i][10:4]}, 4'hF, 33'h0);
      xf(0, 12'h004, 32'h0, 4'hF, {29'h0, tbl[i][3:0]});
    end
    $display("test table done");
    repeat (24) begin
      c = 7'($random(seed));
      xf(1, 12'h000, {25'h0, c}, 4'hF, 33'h0);
      xf(0, 12'h004, 32'h0, 4'hF, {29'h0, dec(c)});
    end
    $display("test random done");
    xf(1, 12'h000, 32'h0, 4'h0, 33'h0);
    xf(1, 12'h004, 32'h0, 4'hF, {1'b1, 32'h0});
    xf(0, 12'h008, 32'h0, 4'hF, {1'b1, 32'h0});
    xf(0, 12'h000, 32'h0, 4'hF, {26'h0, c});
    $display("test refuse done");
    @(posedge pclk);
    give_verdict();
  end
endmodule
